// File: hw/pll_regs_pkg.sv
package pll_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets on the serial programming port
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_IDENTITY = 5'h00;
    localparam logic [4:0] ADDR_RESET_CTRL = 5'h01;
    localparam logic [4:0] ADDR_REF_DIVIDE = 5'h02;
    localparam logic [4:0] ADDR_FB_WHOLE = 5'h03;
    localparam logic [4:0] ADDR_FB_FRACTION = 5'h04;
    localparam logic [4:0] ADDR_VCO_PACKET = 5'h05;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int DATA_W = 24;
    localparam int RESET_CTRL_W = 10;
    localparam int REF_DIVIDE_W = 14;
    localparam int FB_WHOLE_W = 19;
    localparam int FB_FRACTION_W = 24;
    localparam int PACKET_W = 16;
    localparam int PAYLOAD_W = 9;
    localparam logic [9:0] RESET_CTRL_RESET = 10'h002;
    localparam logic [13:0] REF_DIVIDE_RESET = 14'h0001;
    localparam logic [18:0] FB_WHOLE_RESET = 19'h00019;
    localparam logic [23:0] FB_FRACTION_RESET = 24'h000000;
    localparam logic [15:0] VCO_PACKET_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TARGET_LSB = 0;
    localparam int TARGET_MSB = 2;
    localparam int POINTER_LSB = 3;
    localparam int POINTER_MSB = 6;
    localparam int PAYLOAD_LSB = 7;
    localparam int PAYLOAD_MSB = 15;
    localparam int READ_PTR_MSB = 4;
    localparam int SOFT_RESET_BIT = 5;
    localparam logic [2:0] VCO_TARGET_CODE = 3'h0;

    // ------------------------------------------------------------
    // Serial frame layout: 24 data, 5 address, 3 chip address
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int FRAME_ADDR_LSB = 3;
    localparam int FRAME_DATA_LSB = 8;
    localparam logic [2:0] CHIP_ADDRESS = 3'h0;

    // ------------------------------------------------------------
    // Internal link timing
    // ------------------------------------------------------------
    localparam int LINK_DIVIDE = 4;
    localparam int LINK_MAX_HZ = 50_000_000;
    localparam int CLOCK_HZ = 25_000_000;

endpackage

// File: hw/pll_regs_vco_indirect_access.sv
// Contract
// - Packet splits into target, pointer, payload fields.
// - Subsystem answers only target code zero.
// - Each packet write launches a link transfer unless the link is busy; then it is dropped.
// - Calibration overwrites only the payload field.
// - Calibration never touches target or pointer.
// - Packet read returns last transferred packet only.
// - Address zero reads fixed 24-bit identity.
// - Address zero write sets next read pointer.
// - Bit five at address zero soft-resets port.
// - Reference divider 14 bits, resets to one.
// - Whole divider 19 bits, resets to 25.
// - Fraction field 24 bits unsigned, resets zero.
// - Reset control register ten bits, resets 002h.
// - Link clocked from divided reference clock.
// - Packet shifted out most significant bit first.
// - Selected register shifted out in the next frame.
`timescale 1ns/1ps
module pll_regs_vco_indirect_access #(
    parameter logic [23:0] IDENTITY_CODE = 24'h00C0DE, // Arbitrary value
    parameter int LINK_DIVIDE = pll_regs_pkg::LINK_DIVIDE
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sen,
    input wire logic lock_detect,
    input wire logic reference_buffer_on,
    input wire logic cal_payload_valid,
    input wire logic [8:0] cal_payload,
    output logic cal_payload_ready,
    output logic lock_or_serial_out_pin,
    output logic soft_reset_pulse,
    output logic [9:0] reserved_reset_control,
    output logic [13:0] reference_divide,
    output logic reference_divider_active,
    output logic [18:0] feedback_whole_part,
    output logic [23:0] feedback_fraction_part,
    output logic [15:0] vco_indirect_packet,
    output logic [2:0] subsystem_target_code,
    output logic [3:0] subsystem_register_pointer,
    output logic [8:0] subsystem_payload,
    output logic link_clk,
    output logic link_data,
    output logic link_enable,
    output logic link_busy
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // The serial pins are sampled on ref_clk, so the port clock must run
    // well below a quarter of ref_clk; faster host clocks are not served.
    logic [2:0] sclk_sync;
    logic [2:0] sen_sync;
    logic [1:0] sdi_sync;
    logic sclk_rise, sclk_fall, sen_rise;

    // Three stages on clock and strobe so the edge detect reads stages two and three only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 3'h0;
            sen_sync <= 3'h0;
            sdi_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk};
            sen_sync <= {sen_sync[1:0], sen};
            sdi_sync <= {sdi_sync[0], sdi};
        end
    end

    // Edge detection on the settled stages
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign sen_rise = sen_sync[1] & ~sen_sync[2];

    // ------------------------------------------------------------
    // Serial frame capture and readback shifting
    // ------------------------------------------------------------
    logic [31:0] frame_shift, next_frame_shift;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [23:0] read_shift, next_read_shift;
    logic [4:0] read_pointer, next_read_pointer;
    logic [23:0] readback_word;
    logic frame_commit;
    logic [4:0] frame_addr;
    logic [23:0] frame_data;
    logic soft_reset_hit;

    // A frame commits only when exactly 32 bits arrived for our chip address
    assign frame_addr = frame_shift[pll_regs_pkg::FRAME_ADDR_LSB +: 5];
    assign frame_data = frame_shift[pll_regs_pkg::FRAME_DATA_LSB +: 24];
    assign frame_commit = sen_rise && (bit_cnt == 6'(pll_regs_pkg::FRAME_BITS))
        && (frame_shift[2:0] == pll_regs_pkg::CHIP_ADDRESS);
    assign soft_reset_hit = frame_commit && (frame_addr == pll_regs_pkg::ADDR_IDENTITY)
        && frame_data[pll_regs_pkg::SOFT_RESET_BIT];

    // Read word chosen by the stored pointer; unknown addresses read zero
    always_comb begin
        case (read_pointer)
            pll_regs_pkg::ADDR_IDENTITY: readback_word = IDENTITY_CODE;
            pll_regs_pkg::ADDR_RESET_CTRL: readback_word = {14'h0000, reserved_reset_control};
            pll_regs_pkg::ADDR_REF_DIVIDE: readback_word = {10'h000, reference_divide};
            pll_regs_pkg::ADDR_FB_WHOLE: readback_word = {5'h00, feedback_whole_part};
            pll_regs_pkg::ADDR_FB_FRACTION: readback_word = feedback_fraction_part;
            pll_regs_pkg::ADDR_VCO_PACKET: readback_word = {8'h00, vco_indirect_packet};
            default: readback_word = 24'h000000;
        endcase
    end

    // Frame bookkeeping; between frames the read word is reloaded so the
    // next frame always carries fresh contents of the selected register
    always_comb begin
        next_frame_shift = frame_shift;
        next_bit_cnt = bit_cnt;
        next_read_shift = read_shift;
        next_read_pointer = read_pointer;
        if (bit_cnt == 6'h00) begin
            next_read_shift = readback_word;
        end else if (sclk_fall && bit_cnt < 6'(pll_regs_pkg::DATA_W)) begin
            next_read_shift = {read_shift[22:0], 1'b0};
        end
        if (sclk_rise) begin
            next_frame_shift = {frame_shift[30:0], sdi_sync[1]};
            if (bit_cnt != 6'h3F) begin
                next_bit_cnt = bit_cnt + 6'h01;
            end
        end
        if (sen_rise) begin
            next_bit_cnt = 6'h00;
        end
        if (frame_commit && frame_addr == pll_regs_pkg::ADDR_IDENTITY) begin
            next_read_pointer = frame_data[pll_regs_pkg::READ_PTR_MSB:0];
        end
        if (soft_reset_hit) begin
            next_read_pointer = 5'h00;
            next_frame_shift = 32'h00000000;
        end
    end

    // Serial port state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_shift <= 32'h00000000;
            bit_cnt <= 6'h00;
            read_shift <= 24'h000000;
            read_pointer <= 5'h00;
        end else begin
            frame_shift <= next_frame_shift;
            bit_cnt <= next_bit_cnt;
            read_shift <= next_read_shift;
            read_pointer <= next_read_pointer;
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    logic [9:0] next_reserved_reset_control;
    logic [13:0] next_reference_divide;
    logic [18:0] next_feedback_whole_part;
    logic [23:0] next_feedback_fraction_part;
    logic [15:0] next_vco_indirect_packet;
    logic next_soft_reset_pulse;
    logic pout_pin, next_pout_pin;
    logic host_packet_write;
    logic link_start;
    logic [15:0] link_packet;

    vco_link_if link_ctl ();

    // A new packet is refused while the link is busy so the stored packet
    // always equals the one actually sent
    assign host_packet_write = frame_commit && (frame_addr == pll_regs_pkg::ADDR_VCO_PACKET) && !link_ctl.busy;
    assign cal_payload_ready = !link_ctl.busy && !host_packet_write;

    // Host writes win over calibration in the same cycle
    always_comb begin
        link_start = 1'b0;
        link_packet = vco_indirect_packet;
        if (host_packet_write) begin
            link_start = 1'b1;
            link_packet = frame_data[15:0];
        end else if (cal_payload_valid && cal_payload_ready) begin
            link_start = 1'b1;
            // Only the payload changes; target and pointer stay as the host left them
            link_packet = {cal_payload, vco_indirect_packet[pll_regs_pkg::POINTER_MSB:0]};
        end
    end

    // Next values for the writable registers
    always_comb begin
        next_reserved_reset_control = reserved_reset_control;
        next_reference_divide = reference_divide;
        next_feedback_whole_part = feedback_whole_part;
        next_feedback_fraction_part = feedback_fraction_part;
        next_vco_indirect_packet = vco_indirect_packet;
        next_soft_reset_pulse = soft_reset_hit;
        if (frame_commit) begin
            case (frame_addr)
                pll_regs_pkg::ADDR_RESET_CTRL: next_reserved_reset_control = frame_data[9:0];
                pll_regs_pkg::ADDR_REF_DIVIDE: next_reference_divide = frame_data[13:0];
                pll_regs_pkg::ADDR_FB_WHOLE: next_feedback_whole_part = frame_data[18:0];
                pll_regs_pkg::ADDR_FB_FRACTION: next_feedback_fraction_part = frame_data;
                default: next_reserved_reset_control = reserved_reset_control;
            endcase
        end
        if (link_start) begin
            next_vco_indirect_packet = link_packet;
        end
        // Pin shows read data while a frame is under way, else lock state
        if (bit_cnt != 6'h00) begin
            next_pout_pin = read_shift[23];
        end else begin
            next_pout_pin = lock_detect;
        end
    end

    // Register bank flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reserved_reset_control <= pll_regs_pkg::RESET_CTRL_RESET;
            reference_divide <= pll_regs_pkg::REF_DIVIDE_RESET;
            feedback_whole_part <= pll_regs_pkg::FB_WHOLE_RESET;
            feedback_fraction_part <= pll_regs_pkg::FB_FRACTION_RESET;
            vco_indirect_packet <= pll_regs_pkg::VCO_PACKET_RESET;
            soft_reset_pulse <= 1'b0;
            pout_pin <= 1'b0;
        end else begin
            reserved_reset_control <= next_reserved_reset_control;
            reference_divide <= next_reference_divide;
            feedback_whole_part <= next_feedback_whole_part;
            feedback_fraction_part <= next_feedback_fraction_part;
            vco_indirect_packet <= next_vco_indirect_packet;
            soft_reset_pulse <= next_soft_reset_pulse;
            pout_pin <= next_pout_pin;
        end
    end

    assign lock_or_serial_out_pin = pout_pin;

    // ------------------------------------------------------------
    // Field view of the last packet and divider gating
    // ------------------------------------------------------------
    // The divider only takes effect with the reference buffer on
    assign reference_divider_active = reference_buffer_on && (reference_divide != 14'h0000);
    assign subsystem_target_code = vco_indirect_packet[pll_regs_pkg::TARGET_MSB:pll_regs_pkg::TARGET_LSB];
    assign subsystem_register_pointer = vco_indirect_packet[pll_regs_pkg::POINTER_MSB:pll_regs_pkg::POINTER_LSB];
    assign subsystem_payload = vco_indirect_packet[pll_regs_pkg::PAYLOAD_MSB:pll_regs_pkg::PAYLOAD_LSB];

    // ------------------------------------------------------------
    // Internal link to the oscillator subsystem
    // ------------------------------------------------------------
    assign link_ctl.start = link_start;
    assign link_ctl.packet = link_packet;
    assign link_busy = link_ctl.busy;

    vco_link_shifter #(
        .DIVIDE(LINK_DIVIDE)
    ) u_link (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ctl(link_ctl.sink),
        .link_clk(link_clk),
        .link_data(link_data),
        .link_enable(link_enable)
    );

endmodule

// File: hw/vco_link_if.sv
`timescale 1ns/1ps
interface vco_link_if;
    logic start;
    logic [15:0] packet;
    logic busy;

    modport source (
        output start,
        output packet,
        input busy
    );
    modport sink (
        input start,
        input packet,
        output busy
    );
endinterface

// File: hw/vco_link_shifter.sv
`timescale 1ns/1ps
module vco_link_shifter #(
    parameter int DIVIDE = pll_regs_pkg::LINK_DIVIDE
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    vco_link_if.sink ctl,
    output logic link_clk,
    output logic link_data,
    output logic link_enable
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    initial begin
        if (DIVIDE < 2 || (DIVIDE % 2) != 0 || DIVIDE > 256) begin
            $error("DIVIDE must be even and between 2 and 256");
        end
        if (pll_regs_pkg::CLOCK_HZ / DIVIDE * 2 > pll_regs_pkg::LINK_MAX_HZ * 2) begin
            $error("link clock exceeds its limit");
        end
    end

    localparam logic [7:0] HALF_LAST = 8'(DIVIDE / 2 - 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_t;

    shift_state_t state, next_state;
    logic [7:0] half_cnt, next_half_cnt;
    logic [3:0] bit_idx, next_bit_idx;
    logic [15:0] shreg, next_shreg;
    logic next_link_clk;

    // Link clock idles low; the far end samples on the rising edge
    // and data moves on the falling edge, MSB first
    always_comb begin
        next_state = state;
        next_half_cnt = half_cnt;
        next_bit_idx = bit_idx;
        next_shreg = shreg;
        next_link_clk = link_clk;
        case (state)
            ST_IDLE: begin
                next_link_clk = 1'b0;
                if (ctl.start) begin
                    next_state = ST_SHIFT;
                    next_shreg = ctl.packet;
                    next_half_cnt = 8'h00;
                    next_bit_idx = 4'h0;
                end
            end
            ST_SHIFT: begin
                if (half_cnt == HALF_LAST) begin
                    next_half_cnt = 8'h00;
                    next_link_clk = ~link_clk;
                    if (link_clk) begin
                        next_shreg = {shreg[14:0], 1'b0};
                        next_bit_idx = bit_idx + 4'h1;
                        if (bit_idx == 4'hF) begin
                            next_state = ST_IDLE;
                        end
                    end
                end else begin
                    next_half_cnt = half_cnt + 8'h01;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_link_clk = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            half_cnt <= 8'h00;
            bit_idx <= 4'h0;
            shreg <= 16'h0000;
            link_clk <= 1'b0;
        end else begin
            state <= next_state;
            half_cnt <= next_half_cnt;
            bit_idx <= next_bit_idx;
            shreg <= next_shreg;
            link_clk <= next_link_clk;
        end
    end

    assign link_data = shreg[15];
    assign link_enable = (state == ST_SHIFT);
    assign ctl.busy = (state == ST_SHIFT);

endmodule

// File: test/pll_regs_vco_indirect_access_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checks of the register bank
// ----------------------------------------
module pll_regs_checker #(
    parameter int LINK_DIVIDE = 4
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reference_buffer_on,
    input wire logic cal_payload_valid,
    input wire logic [8:0] cal_payload,
    input wire logic cal_payload_ready,
    input wire logic soft_reset_pulse,
    input wire logic [13:0] reference_divide,
    input wire logic reference_divider_active,
    input wire logic [15:0] vco_indirect_packet,
    input wire logic [2:0] subsystem_target_code,
    input wire logic [3:0] subsystem_register_pointer,
    input wire logic [8:0] subsystem_payload,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_enable,
    input wire logic link_busy
);
    localparam int HALF = LINK_DIVIDE / 2;
    localparam int BUSY_LEN = 16 * LINK_DIVIDE;
    int busy_cnt;
    int next_busy_cnt;
    int phase_cnt;
    int next_phase_cnt;
    logic clk_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Busy and link clock phase lengths
    always_comb begin
        next_busy_cnt = link_busy ? busy_cnt + 1 : 0;
        next_phase_cnt = !link_enable ? 0 : (link_clk != clk_q) ? 1 : phase_cnt + 1;
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 0;
            phase_cnt <= 0;
            clk_q <= 1'b0;
        end else begin
            busy_cnt <= next_busy_cnt;
            phase_cnt <= next_phase_cnt;
            clk_q <= link_clk;
        end
    end

    a_field_split: assert property (subsystem_target_code == vco_indirect_packet[2:0]
        && subsystem_register_pointer == vco_indirect_packet[6:3] && subsystem_payload == vco_indirect_packet[15:7])
        else $error("packet fields differ from packet");
    a_cal_payload_only: assert property (cal_payload_valid && cal_payload_ready |=>
        subsystem_payload == $past(cal_payload)) else $error("calibration payload not stored");
    a_cal_keeps_addr: assert property (cal_payload_valid && cal_payload_ready |=>
        $stable(vco_indirect_packet[6:0])) else $error("calibration changed target or pointer");
    a_cal_launches: assert property (cal_payload_valid && cal_payload_ready |=> link_busy && link_enable)
        else $error("no transfer after calibration write");
    a_busy_blocks: assert property (link_busy |-> !cal_payload_ready) else $error("ready while busy");
    a_busy_length: assert property ($fell(link_busy) |-> busy_cnt == BUSY_LEN) else $error("busy length wrong");
    a_link_phase: assert property (link_enable && link_clk != clk_q |-> phase_cnt == HALF)
        else $error("link clock phase length wrong");
    a_link_idle: assert property (!link_enable |-> !link_clk) else $error("link clock outside transfer");
    a_msb_first: assert property ($rose(link_enable) |-> link_data == vco_indirect_packet[15])
        else $error("first link bit is not the top bit");
    a_data_holds: assert property (link_enable && link_clk |-> $stable(link_data))
        else $error("link data moved while clock high");
    a_soft_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse) else $error("soft reset pulse too long");
    a_reference_divide_gate: assert property (reference_divider_active ==
        (reference_buffer_on && reference_divide != 14'h0000)) else $error("divider enable wrong");
    c_cal: cover property (cal_payload_valid && cal_payload_ready);
    c_soft: cover property ($rose(soft_reset_pulse));
    c_done: cover property ($fell(link_busy));
endmodule

bind pll_regs_vco_indirect_access pll_regs_checker #(.LINK_DIVIDE(LINK_DIVIDE)) chk_u (.*);

// File: test/pll_regs_vco_indirect_access_tb.sv
`timescale 1ns/1ps
`define check_eq(act, exp) \
    begin \
        compares++; \
        if ((act) !== (exp)) begin \
            miscompares++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (act), (exp)); \
        end \
    end
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module pll_regs_vco_indirect_access_tb;
    localparam logic [23:0] ID_CODE = 24'h5A3C96; // Arbitrary value
    logic ref_clk = 1'b0;
    logic reset_n, lock_detect, reference_buffer_on, cal_payload_valid, sclk, sdi, sen;
    logic [8:0] cal_payload;
    logic cal_payload_ready, lock_or_serial_out_pin, soft_reset_pulse, reference_divider_active;
    logic [9:0] reserved_reset_control;
    logic [13:0] reference_divide;
    logic [18:0] feedback_whole_part;
    logic [23:0] feedback_fraction_part, rd;
    logic [15:0] vco_indirect_packet, cap, pkt;
    logic [2:0] subsystem_target_code;
    logic [3:0] subsystem_register_pointer;
    logic [8:0] subsystem_payload;
    logic link_clk, link_data, link_enable, link_busy;
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    int nbits = 0;
    int pulses = 0;
    logic [23:0] wval [1:4] = '{24'h0003FF, 24'h003FFF, 24'h07FFFC, 24'hFFFFFF};

    always #20 ref_clk = ~ref_clk;

    pll_regs_vco_indirect_access #(.IDENTITY_CODE(ID_CODE)) dut_u (.*);
    serial_host_model host_u (.*);

    // Far end of the link samples on the rising link clock
    always @(posedge link_clk) begin
        if (link_enable === 1'b1) begin
            cap = {cap[14:0], link_data};
            nbits++;
        end
    end
    // Pulse count and cycle ceiling
    always @(posedge ref_clk) begin
        if (soft_reset_pulse === 1'b1) pulses++;
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check_link(input logic [15:0] exp);
        host_u.wait_idle();
        `check_eq(nbits, 16)
        `check_eq(cap, exp)
    endtask
    task automatic finish_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        lock_detect = 1'b0;
        reference_buffer_on = 1'b1;
        cal_payload_valid = 1'b0;
        cal_payload = 9'h000;
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        `check_eq(reserved_reset_control, 10'h002)
        `check_eq(reference_divide, 14'h0001)
        `check_eq(feedback_whole_part, 19'h00019)
        `check_eq(feedback_fraction_part, 24'h000000)
        `check_eq(vco_indirect_packet, 16'h0000)
        reference_buffer_on = 1'b0;
        lock_detect = 1'b1;
        repeat (2) @(negedge ref_clk);
        `check_eq(reference_divider_active, 1'b0)
        `check_eq(lock_or_serial_out_pin, 1'b1)
        reference_buffer_on = 1'b1;
        host_u.read_reg(5'h00, rd);
        `check_eq(rd, ID_CODE)
        // Boundary values, read back
        for (int a = 1; a <= 4; a++) begin
            host_u.write_reg(5'(a), wval[a]);
            host_u.read_reg(5'(a), rd);
            `check_eq(rd, wval[a])
        end
        `check_eq(reserved_reset_control, 10'h3FF)
        `check_eq(reference_divide, 14'h3FFF)
        `check_eq(feedback_whole_part, 19'h7FFFC)
        `check_eq(feedback_fraction_part, 24'hFFFFFF)
        host_u.frame(24'h000014, 5'h03, 3'h1, rd);
        `check_eq(feedback_whole_part, 19'h7FFFC)
        host_u.write_reg(5'h06, 24'h123456);
        host_u.read_reg(5'h06, rd);
        `check_eq(rd, 24'h000000)
        // Manual packet to subsystem register 2
        nbits = 0;
        host_u.write_reg(5'h05, 24'h007F10);
        `check_eq(link_busy, 1'b1)
        `check_eq(subsystem_target_code, 3'h0)
        `check_eq(subsystem_register_pointer, 4'h2)
        `check_eq(subsystem_payload, 9'h0FE)
        check_link(16'h7F10);
        host_u.read_reg(5'h05, rd);
        `check_eq(rd, 24'h007F10)
        // Calibration with a stale pointer still in place
        nbits = 0;
        cal_payload = 9'h1A5;
        cal_payload_valid = 1'b1;
        @(negedge ref_clk);
        cal_payload_valid = 1'b0;
        `check_eq(vco_indirect_packet, 16'hD290)
        `check_eq(cal_payload_ready, 1'b0)
        check_link(16'hD290);
        nbits = 0;
        host_u.manual_reset(8'hC5, pkt);
        `check_eq(vco_indirect_packet, 16'hC500)
        check_link(16'hC500);
        // Soft reset drops the stored read pointer
        host_u.write_reg(5'h00, 24'h000003);
        host_u.write_reg(5'h00, 24'h000023);
        `check_eq(pulses, 1)
        host_u.frame(24'h000000, 5'h00, 3'h0, rd);
        `check_eq(rd, ID_CODE)
        finish_test();
    end
endmodule

// File: test/serial_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host on the serial programming port
// ----------------------------------------
module serial_host_model #(
    parameter int PH = 8
) (
    input wire logic ref_clk,
    input wire logic link_busy,
    input wire logic lock_or_serial_out_pin,
    output logic sclk,
    output logic sdi,
    output logic sen
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        sen = 1'b0;
    end

    // One frame MSB first; readback sampled late in the high phase of each of the first 24 bits
    task automatic frame(input logic [23:0] d, input logic [4:0] a, input logic [2:0] chip, output logic [23:0] rd);
        logic [31:0] bits;
        bits = {d, a, chip};
        rd = 24'h000000;
        for (int i = 31; i >= 0; i--) begin
            @(negedge ref_clk);
            sdi = bits[i];
            repeat (PH - 1) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (PH - 1) @(negedge ref_clk);
            if (i >= 8) rd = {rd[22:0], lock_or_serial_out_pin};
            @(negedge ref_clk);
            sclk = 1'b0;
        end
        repeat (PH) @(negedge ref_clk);
        sen = 1'b1;
        sdi = ~sdi; // Released line shows the inverse, not a stale bit
        repeat (PH) @(negedge ref_clk);
        sen = 1'b0;
        repeat (PH) @(negedge ref_clk);
    endtask
    task automatic write_reg(input logic [4:0] a, input logic [23:0] d);
        logic [23:0] unused;
        frame(d, a, 3'h0, unused);
    endtask
    // Two frames: set the pointer, then repeat it while data comes out
    task automatic read_reg(input logic [4:0] a, output logic [23:0] rd);
        logic [23:0] ptr;
        ptr = {19'h00000, a}; // Upper bits and soft reset left at zero
        write_reg(5'h00, ptr);
        frame(ptr, 5'h00, 3'h0, rd);
    endtask
    // Dropped packets are lost, so wait out the transfer first
    task automatic wait_idle();
        int n;
        n = 0;
        while (link_busy !== 1'b0 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    // Subsystem reset keeping switch bits; pointer back to zero
    task automatic manual_reset(input logic [7:0] sw, output logic [15:0] pkt);
        pkt = {sw, 1'b0, 4'h0, 3'h0};
        wait_idle();
        write_reg(5'h05, {8'h00, pkt});
    endtask
endmodule
